// ===== cfr_pkg.sv
/*
 * cfr_pkg: shared constants for the contactless frame receive
 * configuration block: register indexes, field positions, reset values
 * and timing counts.
 * assumes a 50 MHz system clock and a 13.56 MHz carrier reference.
 */
package cfr_pkg;

    // ************************************************************
    // register map (index; byte address is four times the index)
    // ************************************************************
    localparam logic [7:0] FRAME_FORMAT_CONTROL_IDX = 8'h33; // frame format
    localparam logic [7:0] RECEIVE_START_DETECT_IDX = 8'h34; // start detect
    localparam logic [7:0] RECEIVE_CONTROL_IDX      = 8'h35; // receive control
    localparam logic [7:0] RECEIVE_HOLDOFF_IDX      = 8'h36; // receive hold-off

    // ************************************************************
    // field positions
    // ************************************************************
    localparam int TX_PARITY_GENERATE_BIT    = 7;
    localparam int RX_PARITY_CHECK_BIT       = 6;
    localparam int FRAME_END_SYMBOL_LSB      = 2;
    localparam int FRAME_BEGIN_SYMBOL_LSB    = 0;
    localparam int START_IRQ_ENABLE_BIT      = 5;
    localparam int START_SEEN_FLAG_BIT       = 4;
    localparam int SUBCARRIER_IRQ_ENABLE_BIT = 2;
    localparam int SUBCARRIER_SEEN_FLAG_BIT  = 1;
    localparam int SUBCARRIER_LIVE_BIT       = 0;
    localparam int ALLOW_PARTIAL_BYTE_BIT    = 7;
    localparam int MULTI_FRAME_RECEIVE_BIT   = 6;
    localparam int FRAME_END_TYPE_BIT        = 5;
    localparam int GUARD_TIME_CHECK_BIT      = 4;
    localparam int INTERFERENCE_SUPPRESS_BIT = 3;
    localparam int RX_RATE_LSB               = 0;
    localparam int HOLDOFF_UNIT_SEL_BIT      = 7;

    // ************************************************************
    // reset values and writable masks
    // ************************************************************
    localparam logic [7:0] FRAME_FORMAT_RESET = 8'h00;
    localparam logic [7:0] START_DETECT_RESET = 8'h00;
    localparam logic [7:0] RX_CONTROL_RESET   = 8'h04; // 106 kBd
    localparam logic [7:0] RX_HOLDOFF_RESET   = 8'h00;
    localparam logic [7:0] FRAME_FORMAT_MASK  = 8'hcf; // bits 5:4 reserved
    localparam logic [7:0] START_DETECT_MASK  = 8'h24; // enables only

    // ************************************************************
    // timing
    // ************************************************************
    localparam int CLK_KHZ       = 50000;
    localparam int CARRIER_KHZ   = 13560;
    localparam int CARRIER_UNIT  = 16;   // carrier periods per hold-off step
    // carrier unit, least time rounded up
    localparam int CARRIER_UNIT_CYCLES =
        (CARRIER_UNIT * CLK_KHZ + CARRIER_KHZ - 1) / CARRIER_KHZ;
    // half a bit at code c spans 1024 >> c carrier periods (code 4 = 106 kBd)
    localparam int HALFBIT_BASE  = 1024;
    localparam int EGT_LIMIT_CYCLES = 1000; // longest gap between characters
    localparam int EMD_BYTES     = 3;

    // half-bit period in system cycles for a bit-rate code, rounded up
    function automatic logic [9:0] halfbit_cycles(input logic [2:0] code);
        int car;
        car = HALFBIT_BASE >> code;
        return 10'((car * CLK_KHZ + CARRIER_KHZ - 1) / CARRIER_KHZ);
    endfunction

    // receive framer states
    typedef enum logic [1:0] {
        CFR_IDLE  = 2'b00,
        CFR_ARMED = 2'b01,
        CFR_FRAME = 2'b10
    } cfr_state_t;

endpackage

// ===== cfr_holdoff_if.sv
/*
 * cfr_holdoff_if: carrier between the register block and the receive
 * hold-off timer.
 * assumes both ends share clk_i.
 */
interface cfr_holdoff_if;
    logic       start;     // transmission just ended
    logic       unit_sel;  // 0 carrier units, 1 half-bit units
    logic [6:0] count;     // hold-off steps
    logic [2:0] tx_rate;   // current transmit bit-rate code
    logic       busy;      // receiver blanked

    modport ctrl  (output start, unit_sel, count, tx_rate, input busy);
    modport timer (input start, unit_sel, count, tx_rate, output busy);
endinterface

// ===== cfr_holdoff.sv
/*
 * cfr_holdoff: blanking timer that masks receiver input after a
 * transmission.
 * assumes start is a one-cycle pulse synchronous to clk_i.
 */
module cfr_holdoff (
    input  wire logic   clk_i,
    input  wire logic   rst_i,
    input  wire logic   ce_i,
    cfr_holdoff_if.timer hif
);

    // ************************************************************
    // step and unit counters
    // ************************************************************
    logic [6:0] step_reg;   // steps still to run
    logic [9:0] unit_reg;   // cycles left in current step
    logic [9:0] unit_len;   // length of one step in cycles

    // carrier unit, or half a bit at the transmit rate
    assign unit_len = hif.unit_sel ? cfr_pkg::halfbit_cycles(hif.tx_rate)
                                   : 10'(cfr_pkg::CARRIER_UNIT_CYCLES);

    // count steps down; busy while any remain
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            step_reg <= 7'h00;
            unit_reg <= 10'h000;
            hif.busy <= 1'b0;
        end else if (ce_i) begin
            if (hif.start) begin
                // restart on every end of transmission
                step_reg <= hif.count;
                unit_reg <= unit_len;
                hif.busy <= (hif.count != 7'h00);
            end else if (step_reg != 7'h00) begin
                if (unit_reg <= 10'h001) begin
                    step_reg <= step_reg - 7'h01;
                    unit_reg <= unit_len;
                    hif.busy <= (step_reg != 7'h01);
                end else begin
                    unit_reg <= unit_reg - 10'h001;
                end
            end
        end
    end

endmodule

// ===== cfr_top.sv
/*
 * cfr_top: frame format and receive configuration of a contactless
 * reader front end, with a classic wishbone register slave.
 * assumes a demodulator delivering bytes with their parity bit, frame
 * start and end pulses, and an external fifo and error register.
 */

module cfr_top (
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    input  wire logic        ce_i,
    // wishbone slave
    input  wire logic        cyc_i,
    input  wire logic        stb_i,
    input  wire logic        we_i,
    input  wire logic [7:0]  adr_i,
    input  wire logic [3:0]  sel_i,
    input  wire logic [31:0] dat_i,
    output logic      [31:0] dat_o,
    output logic             ack_o,
    // transmit side
    input  wire logic        tx_byte_valid_i,
    input  wire logic [7:0]  tx_byte_i,
    input  wire logic        tx_end_i,
    input  wire logic [2:0]  tx_rate_i,
    output logic             tx_parity_valid_o,
    output logic             tx_parity_o,
    output logic [1:0]       frame_begin_symbol_sel_o,
    output logic [1:0]       frame_end_symbol_sel_o,
    // receive side
    input  wire logic        rx_start_i,
    input  wire logic        sof_detect_i,
    input  wire logic        subcarrier_i,
    input  wire logic        rx_byte_valid_i,
    input  wire logic [7:0]  rx_byte_i,
    input  wire logic        rx_parity_i,
    input  wire logic        rx_error_i,
    input  wire logic        rx_frame_end_i,
    input  wire logic [2:0]  rx_last_bits_i,
    input  wire logic [7:0]  rx_partial_i,
    input  wire logic        crc_enable_i,
    input  wire logic [1:0]  frame_end_pattern_i,
    input  wire logic [7:0]  error_reg_i,
    output logic             receive_start_irq_o,
    output logic             rx_done_irq_o,
    output logic             rx_active_o,
    output logic             rx_blank_o,
    output logic             parity_error_o,
    output logic             protocol_error_o,
    output logic             end_check_enable_o,
    output logic             frame_end_type_o,
    output logic [2:0]       rx_rate_o,
    output logic             fifo_wr_o,
    output logic [7:0]       fifo_data_o,
    output logic             fifo_reset_o
);

    // ************************************************************
    // registers and decode
    // ************************************************************
    logic [7:0] frame_format_reg;   // frame format control
    logic [7:0] start_detect_reg;   // enables and sticky flags
    logic [7:0] rx_control_reg;     // receive control
    logic [7:0] rx_holdoff_reg;     // receive hold-off
    logic [7:0] start_detect_next;  // flags after set and clear

    cfr_pkg::cfr_state_t state_reg;
    cfr_pkg::cfr_state_t state_next;
    logic [1:0]  byte_cnt_reg;      // bytes so far, saturating at three
    logic [9:0]  gap_reg;           // cycles since last character
    logic        gap_err_reg;       // guard time already flagged

    cfr_holdoff_if hif ();

    logic [7:0] reg_idx;            // word index from byte address
    logic       req;                // new bus request
    logic       wr;                 // register write this cycle
    logic       wr_ff;              // write to frame format
    logic       wr_sd;              // write to start detect
    logic       wr_rc;              // write to receive control
    logic       wr_rh;              // write to receive hold-off
    logic [7:0] rd_data;            // read mux
    logic       rx_ok;              // receiver input accepted
    logic       byte_in;            // byte accepted
    logic       end_in;             // frame end accepted
    logic       sof_in;             // start accepted
    logic       early;              // still inside the first three bytes
    logic       emd_err;            // early error with suppression on
    logic       emd_short;          // short frame with suppression on
    logic       partial_ok;         // partial final byte may be stored
    logic       type_b;             // type b end of frame
    logic       gap_long;           // guard time exceeded

    assign reg_idx = {2'b00, adr_i[7:2]};
    assign req     = cyc_i & stb_i & ~ack_o;
    assign wr      = req & we_i & sel_i[0];
    assign wr_ff   = wr & (reg_idx == cfr_pkg::FRAME_FORMAT_CONTROL_IDX);
    assign wr_sd   = wr & (reg_idx == cfr_pkg::RECEIVE_START_DETECT_IDX);
    assign wr_rc   = wr & (reg_idx == cfr_pkg::RECEIVE_CONTROL_IDX);
    assign wr_rh   = wr & (reg_idx == cfr_pkg::RECEIVE_HOLDOFF_IDX);

    // read mux; unmapped words read zero
    assign rd_data =
        (reg_idx == cfr_pkg::FRAME_FORMAT_CONTROL_IDX) ? frame_format_reg :
        (reg_idx == cfr_pkg::RECEIVE_START_DETECT_IDX) ? start_detect_reg :
        (reg_idx == cfr_pkg::RECEIVE_CONTROL_IDX)      ? rx_control_reg   :
        (reg_idx == cfr_pkg::RECEIVE_HOLDOFF_IDX)      ? rx_holdoff_reg   :
                                                         8'h00;

    // ************************************************************
    // receive qualifiers
    // ************************************************************
    // input blanked
    assign rx_ok      = rx_active_o & ~hif.busy;
    assign byte_in    = rx_ok & rx_byte_valid_i & (state_reg == cfr_pkg::CFR_FRAME);
    assign end_in     = rx_ok & rx_frame_end_i & (state_reg == cfr_pkg::CFR_FRAME);
    assign sof_in     = rx_ok & sof_detect_i;
    assign early      = (byte_cnt_reg < 2'(cfr_pkg::EMD_BYTES));
    assign emd_err    = rx_control_reg[cfr_pkg::INTERFERENCE_SUPPRESS_BIT]
                        & rx_ok & rx_error_i & early & (state_reg == cfr_pkg::CFR_FRAME);
    assign emd_short  = rx_control_reg[cfr_pkg::INTERFERENCE_SUPPRESS_BIT]
                        & early;
    assign partial_ok = (rx_last_bits_i != 3'h0)
                        & (~crc_enable_i | rx_control_reg[cfr_pkg::ALLOW_PARTIAL_BYTE_BIT]);
    assign type_b     = rx_control_reg[cfr_pkg::FRAME_END_TYPE_BIT];
    assign gap_long   = type_b & rx_control_reg[cfr_pkg::GUARD_TIME_CHECK_BIT]
                        & (gap_reg >= 10'(cfr_pkg::EGT_LIMIT_CYCLES));

    always_comb begin
        start_detect_next = start_detect_reg;
        if (wr_sd) begin
            start_detect_next = (dat_i[7:0] & cfr_pkg::START_DETECT_MASK)
                                | (start_detect_reg & dat_i[7:0] & 8'h12);
        end
        if (sof_in) begin
            start_detect_next[cfr_pkg::START_SEEN_FLAG_BIT] = 1'b1;
        end
        if (subcarrier_i) begin
            start_detect_next[cfr_pkg::SUBCARRIER_SEEN_FLAG_BIT] = 1'b1;
        end
        start_detect_next[cfr_pkg::SUBCARRIER_LIVE_BIT] = subcarrier_i;
    end

    // framer state: idle, armed for a start, inside a frame
    always_comb begin
        state_next = state_reg;
        case (state_reg)
            cfr_pkg::CFR_IDLE: begin
                if (rx_start_i) begin
                    state_next = cfr_pkg::CFR_ARMED;
                end
            end
            cfr_pkg::CFR_ARMED: begin
                if (sof_in) begin
                    state_next = cfr_pkg::CFR_FRAME;
                end
            end
            cfr_pkg::CFR_FRAME: begin
                if (end_in) begin
                    state_next = rx_control_reg[cfr_pkg::MULTI_FRAME_RECEIVE_BIT]
                                 ? cfr_pkg::CFR_ARMED : cfr_pkg::CFR_IDLE;
                end
            end
            default: begin
                state_next = cfr_pkg::CFR_IDLE;
            end
        endcase
    end

    // ************************************************************
    // hold-off timer
    // ************************************************************
    assign hif.start    = tx_end_i;
    assign hif.unit_sel = rx_holdoff_reg[cfr_pkg::HOLDOFF_UNIT_SEL_BIT];
    assign hif.count    = rx_holdoff_reg[6:0];
    assign hif.tx_rate  = tx_rate_i;

    cfr_holdoff u_holdoff (
        .clk_i (clk_i),
        .rst_i (rst_i),
        .ce_i  (ce_i),
        .hif   (hif)
    );

    // ************************************************************
    // bus slave and configuration registers
    // ************************************************************
    // one-wait-state ack, dropped the cycle after
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_o            <= 1'b0;
            dat_o            <= 32'h0000_0000;
            frame_format_reg <= cfr_pkg::FRAME_FORMAT_RESET;
            start_detect_reg <= cfr_pkg::START_DETECT_RESET;
            rx_control_reg   <= cfr_pkg::RX_CONTROL_RESET;
            rx_holdoff_reg   <= cfr_pkg::RX_HOLDOFF_RESET;
        end else if (ce_i) begin
            ack_o            <= req;
            dat_o            <= req ? {24'h00_0000, rd_data} : 32'h0000_0000;
            start_detect_reg <= start_detect_next;
            if (wr_ff) begin
                frame_format_reg <= dat_i[7:0] & cfr_pkg::FRAME_FORMAT_MASK;
            end
            if (wr_rc) begin
                rx_control_reg <= dat_i[7:0];
            end
            if (wr_rh) begin
                rx_holdoff_reg <= dat_i[7:0];
            end
        end
    end

    // ************************************************************
    // transmit framing
    // ************************************************************
    // parity and symbol selects toward the encoder
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            tx_parity_valid_o        <= 1'b0;
            tx_parity_o              <= 1'b0;
            frame_begin_symbol_sel_o <= 2'h0;
            frame_end_symbol_sel_o   <= 2'h0;
        end else if (ce_i) begin
            tx_parity_valid_o <= tx_byte_valid_i
                                 & frame_format_reg[cfr_pkg::TX_PARITY_GENERATE_BIT];
            tx_parity_o       <= ~(^tx_byte_i);
            frame_end_symbol_sel_o   <= frame_format_reg[cfr_pkg::FRAME_END_SYMBOL_LSB +: 2];
            frame_begin_symbol_sel_o <= frame_format_reg[cfr_pkg::FRAME_BEGIN_SYMBOL_LSB +: 2];
        end
    end

    // ************************************************************
    // receive framing
    // ************************************************************
    // configuration and interrupt outputs
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            receive_start_irq_o <= 1'b0;
            rx_blank_o          <= 1'b0;
            end_check_enable_o  <= 1'b0;
            frame_end_type_o    <= 1'b0;
            rx_rate_o           <= 3'h0;
        end else if (ce_i) begin
            receive_start_irq_o <=
                (sof_in & start_detect_reg[cfr_pkg::START_IRQ_ENABLE_BIT])
                | (subcarrier_i & start_detect_reg[cfr_pkg::SUBCARRIER_IRQ_ENABLE_BIT]);
            rx_blank_o         <= hif.busy;
            frame_end_type_o   <= type_b;
            end_check_enable_o <= type_b | (frame_end_pattern_i != 2'h0);
            rx_rate_o          <= rx_control_reg[cfr_pkg::RX_RATE_LSB +: 3];
        end
    end

    // frame sequencing, fifo writes and error detection
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            state_reg        <= cfr_pkg::CFR_IDLE;
            rx_active_o      <= 1'b0;
            byte_cnt_reg     <= 2'h0;
            gap_reg          <= 10'h000;
            gap_err_reg      <= 1'b0;
            fifo_wr_o        <= 1'b0;
            fifo_data_o      <= 8'h00;
            fifo_reset_o     <= 1'b0;
            rx_done_irq_o    <= 1'b0;
            parity_error_o   <= 1'b0;
            protocol_error_o <= 1'b0;
        end else if (ce_i) begin
            state_reg      <= state_next;
            rx_active_o    <= (state_next != cfr_pkg::CFR_IDLE);
            fifo_wr_o      <= 1'b0;
            fifo_reset_o   <= 1'b0;
            rx_done_irq_o  <= 1'b0;
            parity_error_o <= 1'b0;
            protocol_error_o <= 1'b0;
            if (state_reg != cfr_pkg::CFR_FRAME || byte_in) begin
                gap_reg     <= 10'h000;
                gap_err_reg <= 1'b0;
            end else if (gap_reg != 10'h3ff) begin
                gap_reg <= gap_reg + 10'h001;
            end
            if (gap_long && !gap_err_reg) begin
                protocol_error_o <= 1'b1;
                gap_err_reg      <= 1'b1;
            end
            if (sof_in && state_reg == cfr_pkg::CFR_ARMED) begin
                byte_cnt_reg <= 2'h0;
            end
            if (emd_err) begin
                fifo_reset_o <= 1'b1;
                byte_cnt_reg <= 2'h0;
                state_reg    <= cfr_pkg::CFR_ARMED;
            end else if (byte_in) begin
                fifo_wr_o      <= 1'b1;
                fifo_data_o    <= rx_byte_i;
                parity_error_o <= rx_format_parity_fail(rx_byte_i, rx_parity_i);
                if (early) begin
                    byte_cnt_reg <= byte_cnt_reg + 2'h1;
                end
            end else if (end_in) begin
                if (emd_short) begin
                    fifo_reset_o <= 1'b1;
                end else begin
                    rx_done_irq_o <= 1'b1;
                    if (partial_ok) begin
                        fifo_wr_o   <= 1'b1;
                        fifo_data_o <= rx_partial_i;
                    end else if (rx_control_reg[cfr_pkg::MULTI_FRAME_RECEIVE_BIT]) begin
                        fifo_wr_o   <= 1'b1;
                        fifo_data_o <= error_reg_i;
                    end
                end
            end
        end
    end

    // parity fails only when checking is enabled and odd parity breaks
    function automatic logic rx_format_parity_fail(input logic [7:0] d, input logic p);
        return frame_format_reg[cfr_pkg::RX_PARITY_CHECK_BIT] & ~(^{d, p});
    endfunction

endmodule

// ===== cfr_chk.sv
/* cfr_chk: port checks for cfr_top.
   assumes ce_i is held high. */
module cfr_chk (
    input wire logic       clk_i, rst_i, ce_i, cyc_i, stb_i, ack_o,
    input wire logic       tx_byte_valid_i, tx_parity_valid_o, tx_parity_o,
    input wire logic       rx_byte_valid_i, rx_frame_end_i, rx_done_irq_o,
    input wire logic       sof_detect_i, subcarrier_i, receive_start_irq_o,
    input wire logic       fifo_wr_o, fifo_reset_o,
    input wire logic [7:0] tx_byte_i, rx_byte_i, fifo_data_o,
    input wire logic [1:0] frame_begin_symbol_sel_o, frame_end_symbol_sel_o
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);
    // a request seen while the slave is idle
    sequence s_req; cyc_i && stb_i && !ack_o && ce_i; endsequence
    a_ack_next: assert property (s_req |=> ack_o) else $error("ack late");
    a_ack_once: assert property (ack_o && ce_i |=> !ack_o) else $error("ack held");
    a_ack_cause: assert property (ack_o |-> $past(cyc_i && stb_i)) else $error("ack alone");
    a_tx_parity: assert property (tx_parity_valid_o |->
        $past(tx_byte_valid_i) && tx_parity_o == ~^$past(tx_byte_i)) else $error("parity");
    a_fifo_data: assert property (fifo_wr_o && $past(rx_byte_valid_i) |->
        fifo_data_o == $past(rx_byte_i)) else $error("fifo data");
    a_done_cause: assert property (rx_done_irq_o |->
        $past(rx_frame_end_i) && !fifo_reset_o) else $error("done irq");
    a_start_cause: assert property (receive_start_irq_o |->
        $past(sof_detect_i || subcarrier_i)) else $error("start irq");
    a_sym_hold: assert property ($changed({frame_end_symbol_sel_o,
        frame_begin_symbol_sel_o}) |-> $past(ack_o)) else $error("symbol");
endmodule
bind cfr_top cfr_chk u_chk (.*);

// ===== cfr_card.sv
/* cfr_card: card in the field sending one frame.
   assumes send is called just after a rising clock edge. */
module cfr_card (
    input  wire logic  clk_i,
    output logic       sof_o, sub_o, val_o, par_o, err_o, end_o,
    output logic [7:0] byte_o, part_o,
    output logic [2:0] bits_o
);
    initial {sof_o, sub_o, val_o, par_o, err_o, end_o, byte_o, part_o, bits_o} = '0;
    // subcarrier, frame start, n bytes with odd parity, frame end
    // gap: idle cycles after each byte; byte e carries an error and bad parity
    task automatic send(input int n, gap, e);
        sub_o <= 1'b1;
        @(posedge clk_i) sof_o <= 1'b1;
        @(posedge clk_i) sof_o <= 1'b0;
        for (int i = 0; i < n; i++) begin
            {val_o, err_o, byte_o} <= {1'b1, i == e, 8'h5a + 8'(i)};
            par_o <= ~^(8'h5a + 8'(i)) ^ (i == e);
            @(posedge clk_i) {val_o, err_o, byte_o} <= {2'b00, ~byte_o}; // stale data toggles
            repeat (gap) @(posedge clk_i);
        end
        // three-bit tail byte comes with every frame end
        {end_o, bits_o, part_o} <= {1'b1, 3'h3, 8'h07};
        @(posedge clk_i) {end_o, sub_o} <= 2'b00;
    endtask
endmodule

// ===== test_cfr_top.sv
/* test_cfr_top: directed bench for cfr_top.
   assumes cfr_pkg, cfr_card and cfr_chk are compiled first. */
module test_cfr_top;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk_i = 0, rst_i = 1, ce_i = 1, cyc_i = 0, stb_i = 0, we_i = 0, crc_enable_i = 1;
    logic tx_byte_valid_i = 0, tx_end_i = 0, rx_start_i = 0, ack_o, tx_parity_valid_o;
    logic tx_parity_o, receive_start_irq_o, rx_done_irq_o, rx_active_o, rx_blank_o;
    logic parity_error_o, protocol_error_o, end_check_enable_o, frame_end_type_o;
    logic fifo_wr_o, fifo_reset_o, sof_detect_i, subcarrier_i, rx_byte_valid_i;
    logic rx_parity_i, rx_error_i, rx_frame_end_i;
    logic [1:0] frame_end_pattern_i = 0, frame_begin_symbol_sel_o, frame_end_symbol_sel_o;
    logic [2:0] tx_rate_i = 3'h4, rx_last_bits_i, rx_rate_o;
    logic [3:0] sel_i = 0;
    logic [7:0] adr_i = 0, tx_byte_i = 0, error_reg_i = 0, rx_byte_i, rx_partial_i, fifo_data_o, q;
    logic [7:0] n_wr = 0, n_done = 0, n_rst = 0, n_irq = 0, w0, d0, r0, i0;
    logic [7:0] n_par = 0, n_gap = 0, p0, g0;
    logic [31:0] dat_i = 0, dat_o;
    int error_cnt = 0, tests_run = 0;
    always #10 clk_i = ~clk_i;
    cfr_top DUT (.*);
    cfr_card card (.clk_i, .sof_o(sof_detect_i), .sub_o(subcarrier_i), .val_o(rx_byte_valid_i),
        .par_o(rx_parity_i), .err_o(rx_error_i), .end_o(rx_frame_end_i), .byte_o(rx_byte_i),
        .part_o(rx_partial_i), .bits_o(rx_last_bits_i));
    // pulse counters on the receive outputs
    always @(posedge clk_i) if (!rst_i) begin
        n_wr <= n_wr + 8'(fifo_wr_o); n_done <= n_done + 8'(rx_done_irq_o);
        n_rst <= n_rst + 8'(fifo_reset_o); n_irq <= n_irq + 8'(receive_start_irq_o);
        n_par <= n_par + 8'(parity_error_o); n_gap <= n_gap + 8'(protocol_error_o);
    end
    task automatic chk(input logic [7:0] s, e);
        tests_run++;
        if (s !== e) begin
            error_cnt++;
            $display("MISMATCH at %0t: saw %h want %h", $time, s, e);
        end
    endtask
    // one classic cycle; read data lands in q
    task automatic wb(input logic w, input logic [7:0] a, d);
        {cyc_i, stb_i, we_i, adr_i, sel_i, dat_i} <= {2'b11, w, a, 4'h1, 24'h0, d};
        do @(posedge clk_i); while (ack_o !== 1'b1);
        q = dat_o[7:0];
        {cyc_i, stb_i, we_i, sel_i} <= '0;
        @(posedge clk_i);
    endtask
    // arm the receiver, let the card send n bytes, then settle
    task automatic frame(input int n, gap, e);
        {w0, d0, r0, i0, p0, g0} = {n_wr, n_done, n_rst, n_irq, n_par, n_gap};
        rx_start_i <= 1;
        @(posedge clk_i) rx_start_i <= 0;
        @(posedge clk_i) card.send(n, gap, e);
        repeat (3) @(posedge clk_i);
    endtask
    task automatic t_regs;
        wb(0, 8'hd4, 0); chk(q, 8'h04);
        wb(0, 8'hd8, 0); chk(q, 8'h00);
        wb(0, 8'he0, 0); chk(q, 8'h00);
        for (int s = 0; s < 4; s++) begin
            wb(1, 8'hcc, 8'(s * 5)); chk({4'h0, frame_end_symbol_sel_o, frame_begin_symbol_sel_o}, 8'(s * 5));
        end
        for (int r = 7; r > 3; r--) begin
            wb(1, 8'hd4, 8'(r)); chk({5'h0, rx_rate_o}, 8'(r));
        end
        chk({6'h0, frame_end_type_o, end_check_enable_o}, 8'h00);
        frame_end_pattern_i <= 2'h2; wb(1, 8'hd4, 8'h04);
        chk({6'h0, frame_end_type_o, end_check_enable_o}, 8'h01);
        frame_end_pattern_i <= 2'h0; wb(1, 8'hd4, 8'h24);
        chk({6'h0, frame_end_type_o, end_check_enable_o}, 8'h03);
        wb(1, 8'hcc, 8'hff); wb(0, 8'hcc, 0); chk(q, 8'hcf);
        $display("t_regs end");
    endtask
    task automatic t_tx;
        // even then odd count of ones: parity bit 1, then 0
        for (int k = 0; k < 2; k++) begin
            {tx_byte_i, tx_byte_valid_i} <= {8'h3c + 8'(k), 1'b1};
            @(posedge clk_i) tx_byte_valid_i <= 0;
            @(negedge clk_i) chk({6'h0, tx_parity_valid_o, tx_parity_o}, 8'h03 - 8'(k));
            @(posedge clk_i);
        end
        $display("t_tx end");
    endtask
    task automatic t_rx;
        wb(1, 8'hd0, 8'h20); frame(3, 1, 1);
        chk(n_wr - w0, 8'h03); chk(n_done - d0, 8'h01);
        chk(n_par - p0, 8'h01);
        chk(n_irq - i0, 8'h01); chk({7'h0, rx_active_o}, 8'h00);
        wb(0, 8'hd0, 0); chk(q, 8'h32);
        wb(1, 8'hd0, 8'h20); wb(0, 8'hd0, 0); chk(q, 8'h20);
        wb(1, 8'hd4, 8'h0c); frame(2, 1, 9);
        chk(n_rst - r0, 8'h01); chk(n_done - d0, 8'h00);
        // the fifo is never read here while early bytes may drop
        frame(3, 1, 0);
        chk(n_rst - r0, 8'h01); chk(n_wr - w0, 8'h00);
        $display("t_rx end");
    endtask
    task automatic t_modes;
        wb(1, 8'hd4, 8'h30); frame(1, 1100, 9);
        chk(n_gap - g0, 8'h01);
        error_reg_i <= 8'h5c; wb(1, 8'hd4, 8'h40); frame(3, 1, 9);
        chk(n_wr - w0, 8'h04); chk(fifo_data_o, 8'h5c);
        chk({7'h0, rx_active_o}, 8'h01);
        wb(1, 8'hd4, 8'h80); frame(2, 1, 9);
        chk(n_wr - w0, 8'h03); chk(fifo_data_o, 8'h07);
        $display("t_modes end");
    endtask
    task automatic t_hold;
        // two carrier steps of 59 cycles, then one half bit at 106 kBd of 236
        for (int u = 0; u < 2; u++) begin
            wb(1, 8'hd8, u ? 8'h81 : 8'h02);
            tx_end_i <= 1;
            @(posedge clk_i) tx_end_i <= 0;
            repeat (u ? 200 : 100) @(posedge clk_i);
            chk({7'h0, rx_blank_o}, 8'h01);
            repeat (u ? 50 : 25) @(posedge clk_i);
            chk({7'h0, rx_blank_o}, 8'h00);
        end
        $display("t_hold end");
    endtask
    task automatic final_report;
        $display("checks %0d mismatches %0d", tests_run, error_cnt);
        if (error_cnt == 0 && tests_run > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask
    initial begin
        repeat (20) @(posedge clk_i);
        rst_i <= 0;
        @(posedge clk_i);
        t_regs; t_tx; t_rx; t_modes; t_hold;
        final_report;
    end
    initial begin
        #200000;
        error_cnt++;
        final_report;
    end
endmodule
